/* pkg/flash_host_pkg.sv */
package flash_host_pkg;

    // widths of the user address, the pin bus and the data bus
    localparam int unsigned ADDR_W = 19;
    localparam int unsigned PIN_W = 11;
    localparam int unsigned DATA_W = 8;
    localparam int unsigned COL_W = 8;

    // clock and timing figures, each time in ns and its derived cycle count
    localparam int unsigned CLK_PERIOD_NS = 8;
    localparam int unsigned PHASE_NS = 24;
    localparam int unsigned PHASE_CYC = (PHASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [3:0] PHASE_LAST = 4'(PHASE_CYC - 1);
    localparam int unsigned RESET_HOLD_NS = 100;
    localparam int unsigned RESET_HOLD_CYC = (RESET_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [7:0] RESET_HOLD_LAST = 8'(RESET_HOLD_CYC - 1);
    localparam int unsigned FULL_VALID_NS = 1000;
    localparam int unsigned FULL_VALID_CYC = (FULL_VALID_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [7:0] FULL_VALID_LAST = 8'(FULL_VALID_CYC - 1);

    // guarded sequence addresses and codes
    localparam logic [18:0] UNLOCK1_ADDR = 19'h0_5555;
    localparam logic [18:0] UNLOCK2_ADDR = 19'h0_2aaa;
    localparam logic [7:0] UNLOCK1_DATA = 8'haa;
    localparam logic [7:0] UNLOCK2_DATA = 8'h55;
    localparam logic [7:0] ERASE_SETUP = 8'h80;
    localparam logic [7:0] PROGRAM_SETUP = 8'ha0;
    localparam logic [7:0] BLOCK_ERASE_CODE = 8'h30;
    localparam logic [7:0] BLOCK_ERASE_ALT_CODE = 8'h50;
    localparam logic [7:0] CHIP_ERASE_CODE = 8'h10;
    localparam logic [7:0] ID_ENTRY_CODE = 8'h90;
    localparam logic [7:0] ID_EXIT_CODE = 8'hf0;

    // number of writes in each guarded sequence
    localparam logic [2:0] PROGRAM_LEN = 3'h4;
    localparam logic [2:0] ERASE_LEN = 3'h6;
    localparam logic [2:0] ID_LEN = 3'h3;

    // status bit positions and the polling value of a finished erase
    localparam int unsigned POLL_STATUS_BIT = 7;
    localparam int unsigned TOGGLE_STATUS_BIT = 6;
    localparam logic ERASE_DONE_POLL = 1'b1;
    localparam logic [1:0] GOOD_READS_LAST = 2'h2;

    // user commands
    typedef enum logic [2:0] {
        CMD_READ = 3'h0,
        CMD_PROGRAM = 3'h1,
        CMD_BLOCK_ERASE = 3'h2,
        CMD_CHIP_ERASE = 3'h3,
        CMD_ID_READ = 3'h4,
        CMD_RESET = 3'h5
    } cmd_kind_t;

endpackage

/* hw/flash_bus_cycle.sv */
// one read or write bus cycle on the multiplexed pins
module flash_bus_cycle (
    input wire logic core_clk_i,
    input wire logic rst_b_i,
    input wire logic start_i,
    input wire logic write_i,
    input wire logic [18:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic [7:0] pin_dq_i,
    output logic done_o,
    output logic [7:0] rdata_o,
    output logic [10:0] pin_addr_o,
    output logic pin_rc_b_o,
    output logic pin_we_b_o,
    output logic pin_oe_b_o,
    output logic [7:0] pin_dq_o,
    output logic pin_dq_oe_o
);

    typedef enum logic [5:0] {
        CY_IDLE = 6'h01,
        CY_ROW = 6'h02,
        CY_ROWL = 6'h04,
        CY_COL = 6'h08,
        CY_COLH = 6'h10,
        CY_STRB = 6'h20
    } cyc_state_t;

    cyc_state_t state_r, state_nxt;
    logic [3:0] cnt_r, cnt_nxt;
    logic wr_r, wr_nxt;
    logic [18:0] addr_r, addr_nxt;
    logic [7:0] wdata_r, wdata_nxt;
    logic done_nxt;
    logic [7:0] rdata_nxt;
    logic [10:0] pin_addr_nxt;
    logic rc_b_nxt, we_b_nxt, oe_b_nxt, dq_oe_nxt;
    logic last;

    // phase sequencing and pin values for the next cycle
    always_comb
    begin
        state_nxt = state_r;
        cnt_nxt = cnt_r;
        wr_nxt = wr_r;
        addr_nxt = addr_r;
        wdata_nxt = wdata_r;
        done_nxt = 1'b0;
        rdata_nxt = rdata_o;
        last = (cnt_r == flash_host_pkg::PHASE_LAST);
        if (state_r != CY_IDLE)
        begin
            cnt_nxt = last ? 4'h0 : cnt_r + 4'h1;
        end
        unique case (state_r)
            CY_IDLE:
            begin
                cnt_nxt = 4'h0;
                if (start_i)
                begin
                    state_nxt = CY_ROW;
                    wr_nxt = write_i;
                    addr_nxt = addr_i;
                    wdata_nxt = wdata_i;
                end
            end
            CY_ROW: if (last) state_nxt = CY_ROWL;
            CY_ROWL: if (last) state_nxt = CY_COL;
            CY_COL: if (last) state_nxt = CY_COLH;
            CY_COLH: if (last) state_nxt = CY_STRB;
            CY_STRB:
            begin
                if (last)
                begin
                    state_nxt = CY_IDLE;
                    done_nxt = 1'b1;
                    if (!wr_r)
                    begin
                        rdata_nxt = pin_dq_i; // sampled while the gate is still low
                    end
                end
            end
        endcase
        // row on fall of the strobe, column on its rise
        pin_addr_nxt = (state_nxt == CY_COL || state_nxt == CY_COLH || state_nxt == CY_STRB)
            ? {3'h0, addr_nxt[18:11]} : addr_nxt[10:0];
        rc_b_nxt = !(state_nxt == CY_ROWL || state_nxt == CY_COL);
        // write strobe low with output gate high; device latches on its rise
        we_b_nxt = !(state_nxt == CY_STRB && wr_nxt);
        oe_b_nxt = !(state_nxt == CY_STRB && !wr_nxt);
        // drive data only while the gate is high, held one cycle past the strobe rise
        dq_oe_nxt = wr_nxt && (state_nxt == CY_COLH || state_nxt == CY_STRB || state_r == CY_STRB);
    end

    // register state and pins
    always_ff @(posedge core_clk_i)
    begin
        if (!rst_b_i)
        begin
            state_r <= CY_IDLE;
            cnt_r <= 4'h0;
            wr_r <= 1'b0;
            addr_r <= 19'h0_0000;
            wdata_r <= 8'h00;
            done_o <= 1'b0;
            rdata_o <= 8'h00;
            pin_addr_o <= 11'h000;
            pin_rc_b_o <= 1'b1;
            pin_we_b_o <= 1'b1;
            pin_oe_b_o <= 1'b1;
            pin_dq_o <= 8'h00;
            pin_dq_oe_o <= 1'b0;
        end
        else
        begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
            wr_r <= wr_nxt;
            addr_r <= addr_nxt;
            wdata_r <= wdata_nxt;
            done_o <= done_nxt;
            rdata_o <= rdata_nxt;
            pin_addr_o <= pin_addr_nxt;
            pin_rc_b_o <= rc_b_nxt;
            pin_we_b_o <= we_b_nxt;
            pin_oe_b_o <= oe_b_nxt;
            pin_dq_o <= wdata_nxt;
            pin_dq_oe_o <= dq_oe_nxt;
        end
    end

endmodule // flash_bus_cycle

/* hw/flash_program_host.sv */
// Contract
// - row bits 10..0 on strobe fall, column bits 18..11 on strobe rise
// - byte program follows four guarded writes, last carries address and data
// - caller must have erased the target block before programming it
// - block erase is six guarded writes ending with block address and 30H/50H
// - chip erase is six writes ending with 10H at 5555H
// - after a doubtful status read, read twice more and need both valid
module flash_program_host (
    input wire logic core_clk_i,
    input wire logic rst_b_i,
    input wire logic cmd_valid_i,
    input wire flash_host_pkg::cmd_kind_t cmd_kind_i,
    input wire logic [18:0] cmd_addr_i,
    input wire logic [7:0] cmd_data_i,
    output logic cmd_ready_o,
    output logic done_o,
    output logic fail_o,
    output logic [7:0] rdata_o,
    output logic [10:0] pin_addr_o,
    output logic pin_rc_b_o,
    output logic pin_we_b_o,
    output logic pin_oe_b_o,
    output logic pin_rst_b_o,
    input wire logic [7:0] pin_dq_i,
    output logic [7:0] pin_dq_o,
    output logic pin_dq_oe_o
);

    typedef enum logic [8:0] {
        ST_IDLE = 9'h001,
        ST_RESET = 9'h002,
        ST_WRITE = 9'h004,
        ST_POLL = 9'h008,
        ST_SETTLE = 9'h010,
        ST_VERIFY = 9'h020,
        ST_READ = 9'h040,
        ST_EXIT = 9'h080,
        ST_DONE = 9'h100
    } host_state_t;

    host_state_t state_r, state_nxt;
    flash_host_pkg::cmd_kind_t kind_r, kind_nxt;
    logic [18:0] addr_r, addr_nxt;
    logic [7:0] data_r, data_nxt;
    logic [2:0] step_r, step_nxt;
    logic [7:0] wait_r, wait_nxt;
    logic [1:0] good_r, good_nxt;
    logic have_prev_r, have_prev_nxt;
    logic prev_tog_r, prev_tog_nxt;
    logic start_r, start_nxt;
    logic wr_r, wr_nxt;
    logic [18:0] cyc_addr_r, cyc_addr_nxt;
    logic [7:0] cyc_data_r, cyc_data_nxt;
    logic ready_nxt, done_nxt, fail_nxt, dev_rst_b_nxt;
    logic [7:0] rdata_nxt;
    logic cyc_done;
    logic [7:0] cyc_rdata;
    logic [2:0] seq_len;
    logic [26:0] seq_word;
    logic exp_poll, status_ok;

    // number of guarded writes for the held command
    always_comb
    begin
        unique case (kind_r)
            flash_host_pkg::CMD_PROGRAM: seq_len = flash_host_pkg::PROGRAM_LEN;
            flash_host_pkg::CMD_BLOCK_ERASE: seq_len = flash_host_pkg::ERASE_LEN;
            flash_host_pkg::CMD_CHIP_ERASE: seq_len = flash_host_pkg::ERASE_LEN;
            default: seq_len = flash_host_pkg::ID_LEN;
        endcase
    end

    // address and data of guarded write number step_nxt, only known codes are sent
    always_comb
    begin
        seq_word = {flash_host_pkg::UNLOCK1_ADDR, flash_host_pkg::UNLOCK1_DATA};
        unique case (step_nxt)
            3'h0: seq_word = {flash_host_pkg::UNLOCK1_ADDR, flash_host_pkg::UNLOCK1_DATA};
            3'h1: seq_word = {flash_host_pkg::UNLOCK2_ADDR, flash_host_pkg::UNLOCK2_DATA};
            3'h2:
            begin
                if (kind_r == flash_host_pkg::CMD_PROGRAM)
                    seq_word = {flash_host_pkg::UNLOCK1_ADDR, flash_host_pkg::PROGRAM_SETUP};
                else if (kind_r == flash_host_pkg::CMD_ID_READ)
                    seq_word = {flash_host_pkg::UNLOCK1_ADDR, flash_host_pkg::ID_ENTRY_CODE};
                else
                    seq_word = {flash_host_pkg::UNLOCK1_ADDR, flash_host_pkg::ERASE_SETUP};
            end
            3'h3:
            begin
                // program target: caller has erased its block beforehand
                if (kind_r == flash_host_pkg::CMD_PROGRAM)
                    seq_word = {addr_r, data_r};
                else
                    seq_word = {flash_host_pkg::UNLOCK1_ADDR, flash_host_pkg::UNLOCK1_DATA};
            end
            3'h4: seq_word = {flash_host_pkg::UNLOCK2_ADDR, flash_host_pkg::UNLOCK2_DATA};
            default:
            begin
                if (kind_r == flash_host_pkg::CMD_CHIP_ERASE)
                    seq_word = {flash_host_pkg::UNLOCK1_ADDR, flash_host_pkg::CHIP_ERASE_CODE};
                else if (data_r[0])
                    seq_word = {addr_r, flash_host_pkg::BLOCK_ERASE_ALT_CODE};
                else
                    seq_word = {addr_r, flash_host_pkg::BLOCK_ERASE_CODE};
            end
        endcase
    end

    // a status read is good when bit 7 shows the finished value and bit 6 stopped
    always_comb
    begin
        exp_poll = (kind_r == flash_host_pkg::CMD_PROGRAM) ? data_r[flash_host_pkg::POLL_STATUS_BIT]
            : flash_host_pkg::ERASE_DONE_POLL;
        status_ok = have_prev_r && (cyc_rdata[flash_host_pkg::POLL_STATUS_BIT] == exp_poll)
            && (cyc_rdata[flash_host_pkg::TOGGLE_STATUS_BIT] == prev_tog_r);
    end

    // command sequencer
    always_comb
    begin
        state_nxt = state_r;
        kind_nxt = kind_r;
        addr_nxt = addr_r;
        data_nxt = data_r;
        step_nxt = step_r;
        wait_nxt = wait_r;
        good_nxt = good_r;
        have_prev_nxt = have_prev_r;
        prev_tog_nxt = prev_tog_r;
        start_nxt = 1'b0;
        wr_nxt = wr_r;
        cyc_addr_nxt = cyc_addr_r;
        cyc_data_nxt = cyc_data_r;
        fail_nxt = fail_o;
        rdata_nxt = rdata_o;
        unique case (state_r)
            ST_IDLE:
            begin
                // new commands only here, so nothing is written while the device is busy
                if (cmd_valid_i && cmd_ready_o)
                begin
                    kind_nxt = cmd_kind_i;
                    addr_nxt = cmd_addr_i;
                    data_nxt = cmd_data_i;
                    step_nxt = 3'h0;
                    wait_nxt = 8'h00;
                    fail_nxt = 1'b0;
                    unique case (cmd_kind_i)
                        flash_host_pkg::CMD_RESET: state_nxt = ST_RESET;
                        flash_host_pkg::CMD_READ:
                        begin
                            state_nxt = ST_READ;
                            start_nxt = 1'b1;
                            wr_nxt = 1'b0;
                            cyc_addr_nxt = cmd_addr_i;
                        end
                        default: state_nxt = ST_WRITE;
                    endcase
                end
            end
            ST_RESET:
            begin
                // hold the device reset pin low for the reset time
                wait_nxt = wait_r + 8'h01;
                if (wait_r == flash_host_pkg::RESET_HOLD_LAST)
                    state_nxt = ST_DONE;
            end
            ST_WRITE:
            begin
                if (!start_r && !cyc_done && step_r == 3'h0 && wait_r == 8'h00)
                begin
                    start_nxt = 1'b1;
                    wr_nxt = 1'b1;
                    wait_nxt = 8'h01;
                    cyc_addr_nxt = seq_word[26:8];
                    cyc_data_nxt = seq_word[7:0];
                end
                else if (cyc_done)
                begin
                    if (step_r == seq_len - 3'h1)
                    begin
                        start_nxt = 1'b1;
                        wr_nxt = 1'b0;
                        have_prev_nxt = 1'b0;
                        good_nxt = 2'h0;
                        if (kind_r == flash_host_pkg::CMD_ID_READ)
                        begin
                            // identification select lies in address bits 1:0
                            state_nxt = ST_READ;
                            cyc_addr_nxt = {17'h0_0000, addr_r[1:0]};
                        end
                        else
                        begin
                            // status is valid once the last write strobe has risen
                            state_nxt = ST_POLL;
                            cyc_addr_nxt = (kind_r == flash_host_pkg::CMD_CHIP_ERASE) ? 19'h0_0000 : addr_r;
                        end
                    end
                    else
                    begin
                        step_nxt = step_r + 3'h1;
                        start_nxt = 1'b1;
                        cyc_addr_nxt = seq_word[26:8];
                        cyc_data_nxt = seq_word[7:0];
                    end
                end
            end
            ST_POLL:
            begin
                // only status reads while the operation runs
                if (cyc_done)
                begin
                    have_prev_nxt = 1'b1;
                    prev_tog_nxt = cyc_rdata[flash_host_pkg::TOGGLE_STATUS_BIT];
                    start_nxt = 1'b1;
                    good_nxt = status_ok ? good_r + 2'h1 : 2'h0;
                    // completion needs the finishing read and two more good ones
                    if (status_ok && good_r == flash_host_pkg::GOOD_READS_LAST)
                    begin
                        start_nxt = 1'b0;
                        if (kind_r == flash_host_pkg::CMD_PROGRAM)
                        begin
                            state_nxt = ST_SETTLE;
                            wait_nxt = 8'h00;
                        end
                        else
                        begin
                            state_nxt = ST_DONE;
                            rdata_nxt = cyc_rdata;
                        end
                    end
                end
            end
            ST_SETTLE:
            begin
                // wait out the interval before the whole byte is trusted
                wait_nxt = wait_r + 8'h01;
                if (wait_r == flash_host_pkg::FULL_VALID_LAST)
                begin
                    state_nxt = ST_VERIFY;
                    start_nxt = 1'b1;
                end
            end
            ST_VERIFY:
            begin
                if (cyc_done)
                begin
                    state_nxt = ST_DONE;
                    rdata_nxt = cyc_rdata;
                    fail_nxt = (cyc_rdata != data_r);
                end
            end
            ST_READ:
            begin
                if (cyc_done)
                begin
                    rdata_nxt = cyc_rdata;
                    if (kind_r == flash_host_pkg::CMD_ID_READ)
                    begin
                        state_nxt = ST_EXIT;
                        start_nxt = 1'b1;
                        wr_nxt = 1'b1;
                        cyc_data_nxt = flash_host_pkg::ID_EXIT_CODE;
                    end
                    else
                        state_nxt = ST_DONE;
                end
            end
            ST_EXIT: if (cyc_done) state_nxt = ST_DONE;
            ST_DONE: state_nxt = ST_IDLE;
        endcase
        ready_nxt = (state_nxt == ST_IDLE);
        done_nxt = (state_nxt == ST_DONE);
        // device reset low under our reset and during a reset command
        dev_rst_b_nxt = (state_nxt != ST_RESET);
    end

    // register the sequencer
    always_ff @(posedge core_clk_i)
    begin
        if (!rst_b_i)
        begin
            state_r <= ST_IDLE;
            kind_r <= flash_host_pkg::CMD_READ;
            addr_r <= 19'h0_0000;
            data_r <= 8'h00;
            step_r <= 3'h0;
            wait_r <= 8'h00;
            good_r <= 2'h0;
            have_prev_r <= 1'b0;
            prev_tog_r <= 1'b0;
            start_r <= 1'b0;
            wr_r <= 1'b0;
            cyc_addr_r <= 19'h0_0000;
            cyc_data_r <= 8'h00;
            cmd_ready_o <= 1'b0;
            done_o <= 1'b0;
            fail_o <= 1'b0;
            rdata_o <= 8'h00;
            pin_rst_b_o <= 1'b0;
        end
        else
        begin
            state_r <= state_nxt;
            kind_r <= kind_nxt;
            addr_r <= addr_nxt;
            data_r <= data_nxt;
            step_r <= step_nxt;
            wait_r <= wait_nxt;
            good_r <= good_nxt;
            have_prev_r <= have_prev_nxt;
            prev_tog_r <= prev_tog_nxt;
            start_r <= start_nxt;
            wr_r <= wr_nxt;
            cyc_addr_r <= cyc_addr_nxt;
            cyc_data_r <= cyc_data_nxt;
            cmd_ready_o <= ready_nxt;
            done_o <= done_nxt;
            fail_o <= fail_nxt;
            rdata_o <= rdata_nxt;
            pin_rst_b_o <= dev_rst_b_nxt;
        end
    end

    // pin-level bus cycles
    flash_bus_cycle u_cycle (
        .core_clk_i(core_clk_i),
        .rst_b_i(rst_b_i),
        .start_i(start_r),
        .write_i(wr_r),
        .addr_i(cyc_addr_r),
        .wdata_i(cyc_data_r),
        .pin_dq_i(pin_dq_i),
        .done_o(cyc_done),
        .rdata_o(cyc_rdata),
        .pin_addr_o(pin_addr_o),
        .pin_rc_b_o(pin_rc_b_o),
        .pin_we_b_o(pin_we_b_o),
        .pin_oe_b_o(pin_oe_b_o),
        .pin_dq_o(pin_dq_o),
        .pin_dq_oe_o(pin_dq_oe_o)
    );

endmodule // flash_program_host

/* verification/flash_host_checker.sv */
// pin protocol checks on the host side
module flash_host_checker (
    input wire logic core_clk_i,
    input wire logic rst_b_i,
    input wire logic [10:0] pin_addr_o,
    input wire logic pin_rc_b_o,
    input wire logic pin_we_b_o,
    input wire logic pin_oe_b_o,
    input wire logic pin_rst_b_o,
    input wire logic [7:0] pin_dq_o,
    input wire logic pin_dq_oe_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (!rst_b_i);
    a_strobes_apart: assert property (pin_we_b_o || pin_oe_b_o)
        else $error("write and gate low together");
    a_dq_released: assert property (pin_dq_oe_o |-> pin_oe_b_o)
        else $error("host drives data while gated");
    a_write_data: assert property (!pin_we_b_o |-> pin_dq_oe_o && $stable(pin_dq_o))
        else $error("write data not held");
    a_write_width: assert property ($fell(pin_we_b_o) |-> !pin_we_b_o [*3] ##1 pin_we_b_o)
        else $error("write strobe width wrong");
    a_addr_steady: assert property ($changed(pin_rc_b_o) |-> $stable(pin_addr_o))
        else $error("address moves at strobe edge");
    a_col_upper: assert property ($rose(pin_rc_b_o) |-> pin_addr_o[10:8] == 3'h0)
        else $error("column upper pins set");
    a_reset_len: assert property ($fell(pin_rst_b_o) |-> !pin_rst_b_o [*8] ##5 !pin_rst_b_o ##1 pin_rst_b_o)
        else $error("device reset length wrong");
    a_reset_quiet: assert property (!pin_rst_b_o |-> pin_we_b_o && pin_oe_b_o && !pin_dq_oe_o)
        else $error("strobes active in device reset");
endmodule // flash_host_checker

/* verification/flash_dev_model.sv */
// behavioural device behind the multiplexed pins
module flash_dev_model #(
    parameter logic [7:0] MAKER_ID = 8'h3c, // arbitrary value
    parameter logic [7:0] PART_ID = 8'hc3, // arbitrary value
    parameter logic [7:0] CONT_ID = 8'h5e // arbitrary value
) (
    input wire logic clk_i,
    input wire logic [10:0] addr_i,
    input wire logic rc_b_i,
    input wire logic we_b_i,
    input wire logic oe_b_i,
    input wire logic rst_b_i,
    input wire logic [7:0] dq_i,
    output logic [7:0] dq_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] mem [0:524287];
    logic [18:0] a = 19'h0_0000;
    logic [7:0] last = 8'h00;
    logic er = 1'b0, pg = 1'b0, idm = 1'b0, tog = 1'b0;
    int st = 0, n = 0, busy = 0, post = 0, dly = 20;
    initial foreach (mem[i]) mem[i] = 8'hff;
    // row on strobe fall, column on strobe rise
    always @(negedge rc_b_i) a[10:0] = addr_i;
    always @(posedge rc_b_i) a[18:11] = addr_i[7:0];
    // reset pin drops any sequence or operation
    always @(negedge rst_b_i) {st, idm, busy} = '0;
    // data taken on strobe rise, ignored while busy
    always @(posedge we_b_i)
        if (rst_b_i === 1'b1 && busy == 0)
        begin
            if (st == 3 && pg) mem[a] = mem[a] & dq_i;
            if (st == 5 && a == 19'h0_5555 && dq_i == 8'h10) foreach (mem[i]) mem[i] = 8'hff;
            if (st == 5 && (dq_i == 8'h30 || dq_i == 8'h50))
                for (int i = 0; i < 65536; i++) mem[{a[18:16], i[15:0]}] = 8'hff;
            busy = ((st == 3 && pg) || st == 5) ? dly : 0;
            er = st == 5;
            // unlock steps; any other write restarts the sequence at step 0
            n = (st % 3 == 0 && a == 19'h0_5555 && dq_i == 8'haa && !(st == 3 && pg))
                || (st % 3 == 1 && a == 19'h0_2aaa && dq_i == 8'h55)
                || (st == 2 && a == 19'h0_5555 && (dq_i == 8'h80 || dq_i == 8'ha0)) ? st + 1 : 0;
            idm = (st == 2 && dq_i == 8'h90) || (idm && dq_i != 8'hf0);
            pg = st == 2 && dq_i == 8'ha0;
            st = n;
        end
    // status while busy, id codes, low bits unsettled just after a program
    always @(negedge oe_b_i)
    begin
        tog = ~tog;
        if (busy > 0) last = {er ? 1'b0 : ~mem[a][7], tog, 6'h2a}; // every 19-bit address is in range
        else if (idm) last = (a[1:0] == 2'h0) ? MAKER_ID : (a[1:0] == 2'h1) ? PART_ID : CONT_ID;
        else last = (post > 0) ? {mem[a][7], ~mem[a][6:0]} : mem[a];
    end
    // internal operation time, then the settling window after a program
    always @(posedge clk_i)
    begin
        if (busy == 1 && !er) post = 125;
        else if (post > 0) post = post - 1;
        if (busy > 0) busy = busy - 1;
    end
    // pins driven only while gated, otherwise a changing pattern
    assign dq_o = (oe_b_i === 1'b0 && rst_b_i === 1'b1) ? last : ~last;
endmodule // flash_dev_model

/* verification/tb_top.sv */
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk_i = 1'b0, rst_b_i = 1'b0, cmd_valid_i = 1'b0;
    flash_host_pkg::cmd_kind_t cmd_kind_i = flash_host_pkg::CMD_READ;
    logic [18:0] cmd_addr_i = 19'h0_0000;
    logic [7:0] cmd_data_i = 8'h00, rdata_o, pin_dq_o, dev_q, dq_w;
    logic cmd_ready_o, done_o, fail_o, pin_rc_b_o, pin_we_b_o, pin_oe_b_o, pin_rst_b_o, pin_dq_oe_o;
    logic [10:0] pin_addr_o;
    int bad_count = 0, total_checks = 0, cycles = 0;
    assign dq_w = pin_dq_oe_o ? pin_dq_o : dev_q;
    always #4 core_clk_i = ~core_clk_i;
    flash_program_host dut (.core_clk_i, .rst_b_i, .cmd_valid_i, .cmd_kind_i, .cmd_addr_i, .cmd_data_i,
        .cmd_ready_o, .done_o, .fail_o, .rdata_o, .pin_addr_o, .pin_rc_b_o, .pin_we_b_o, .pin_oe_b_o,
        .pin_rst_b_o, .pin_dq_i(dq_w), .pin_dq_o, .pin_dq_oe_o);
    flash_dev_model dev (.clk_i(core_clk_i), .addr_i(pin_addr_o), .rc_b_i(pin_rc_b_o), .we_b_i(pin_we_b_o),
        .oe_b_i(pin_oe_b_o), .rst_b_i(pin_rst_b_o), .dq_i(dq_w), .dq_o(dev_q));
    // hang guard
    always @(posedge core_clk_i) if (++cycles == 20000) close_out(1);
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) bad_count++;
        if (got !== exp) $display("mismatch at %0t got %h expected %h", $time, got, exp);
    endtask
    // one command, back once done has been seen
    task automatic run(input flash_host_pkg::cmd_kind_t k, input logic [18:0] a, input logic [7:0] d);
        @(posedge core_clk_i);
        #1 cmd_kind_i = k;
        cmd_addr_i = a;
        cmd_data_i = d;
        cmd_valid_i = 1'b1;
        do @(posedge core_clk_i); while (cmd_ready_o !== 1'b1);
        #1 cmd_valid_i = 1'b0;
        do @(posedge core_clk_i); while (done_o !== 1'b1);
        #1;
    endtask
    task automatic rd(input logic [18:0] a, input logic [7:0] exp);
        run(flash_host_pkg::CMD_READ, a, 8'h00);
        check(rdata_o, exp);
    endtask
    task automatic t_program();
        rd(19'h7_ffff, 8'hff);
        dev.dly = 300;
        run(flash_host_pkg::CMD_PROGRAM, 19'h1_2345, 8'h5a);
        check(fail_o, 8'h00);
        rd(19'h1_2345, 8'h5a);
        dev.dly = 3;
        run(flash_host_pkg::CMD_PROGRAM, 19'h0_0010, 8'h33);
        run(flash_host_pkg::CMD_PROGRAM, 19'h0_0010, 8'h0f);
        check(fail_o, 8'h01);
        check(rdata_o, 8'h03);
        $display("program test ended");
    endtask
    task automatic t_id_reset();
        for (int i = 0; i < 3; i++)
        begin
            run(flash_host_pkg::CMD_ID_READ, {17'h1_fffc, i[1], i[1] | i[0]}, 8'h00);
            check(rdata_o, i == 0 ? dev.MAKER_ID : i == 1 ? dev.PART_ID : dev.CONT_ID);
        end
        run(flash_host_pkg::CMD_RESET, 19'h0_0000, 8'h00);
        check(pin_rst_b_o, 8'h01);
        rst_b_i = 1'b0;
        repeat (2) @(posedge core_clk_i);
        #1 rst_b_i = 1'b1;
        rd(19'h1_2345, 8'h5a);
        $display("id and reset test ended");
    endtask
    task automatic t_erase();
        dev.dly = 300;
        run(flash_host_pkg::CMD_BLOCK_ERASE, 19'h1_0000, 8'h01);
        rd(19'h1_2345, 8'hff);
        rd(19'h0_0010, 8'h03);
        run(flash_host_pkg::CMD_BLOCK_ERASE, 19'h0_0000, 8'h00);
        rd(19'h0_0010, 8'hff);
        run(flash_host_pkg::CMD_PROGRAM, 19'h7_ffff, 8'h81);
        run(flash_host_pkg::CMD_CHIP_ERASE, 19'h0_0000, 8'h00);
        rd(19'h7_ffff, 8'hff);
        $display("erase test ended");
    endtask
    task automatic close_out(input int extra);
        bad_count += extra;
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    initial
    begin
        repeat (4) @(posedge core_clk_i);
        #1 rst_b_i = 1'b1;
        t_program();
        t_id_reset();
        t_erase();
        close_out(0);
    end
endmodule // tb_top
bind flash_program_host flash_host_checker chk (.core_clk_i, .rst_b_i, .pin_addr_o, .pin_rc_b_o, .pin_we_b_o,
    .pin_oe_b_o, .pin_rst_b_o, .pin_dq_o, .pin_dq_oe_o);
